// ### hw/mnpa_map.svh
// Timing counts, address fields and status codes for the NOR host sequencer
`ifndef MNPA_MAP_SVH
`define MNPA_MAP_SVH
`define MNPA_CLK_NS 50
`define MNPA_WE_LOW_NS 35
`define MNPA_WE_LOW_CYC ((`MNPA_WE_LOW_NS + `MNPA_CLK_NS - 1) / `MNPA_CLK_NS)
`define MNPA_WE_HIGH_NS 25
`define MNPA_WE_HIGH_CYC ((`MNPA_WE_HIGH_NS + `MNPA_CLK_NS - 1) / `MNPA_CLK_NS)
`define MNPA_RD_NS 70
`define MNPA_RD_CYC ((`MNPA_RD_NS + `MNPA_CLK_NS - 1) / `MNPA_CLK_NS)
`define MNPA_RST_PULSE_NS 500
`define MNPA_RST_PULSE_CYC ((`MNPA_RST_PULSE_NS + `MNPA_CLK_NS - 1) / `MNPA_CLK_NS)
`define MNPA_READY_BUSY_NS 20000
`define MNPA_READY_BUSY_CYC ((`MNPA_READY_BUSY_NS + `MNPA_CLK_NS - 1) / `MNPA_CLK_NS)
`define MNPA_READY_IDLE_NS 500
`define MNPA_READY_IDLE_CYC ((`MNPA_READY_IDLE_NS + `MNPA_CLK_NS - 1) / `MNPA_CLK_NS)
`define MNPA_RH_NS 50
`define MNPA_RH_CYC ((`MNPA_RH_NS + `MNPA_CLK_NS - 1) / `MNPA_CLK_NS)
`define MNPA_BANK_LSB 19
`define MNPA_BANK_MSB 21
`define MNPA_GRP_LSB 12
`define MNPA_GRP_MSB 21
`define MNPA_A6 6
`define MNPA_A1 1
`define MNPA_A0 0
`define MNPA_ST_PROT 16'h0001
`define MNPA_ST_UNPROT 16'h0000
`define MNPA_TOGGLE_BIT 6
`define MNPA_PARAM_BASE 22'h3f8000
`define MNPA_TOP_PARAM 22'h3ff000
`define MNPA_FIRST_MAIN 22'h3f0000
`define MNPA_BANK2_BASE 22'h2d0000
`endif

// ### hw/mnpa_pkg.sv
// Types shared by the NOR host sequencer
package mnpa_pkg;
   typedef enum logic [2:0] {MNPA_CMD_WRITE, MNPA_CMD_READ, MNPA_CMD_PROTECT, MNPA_CMD_UNPROTECT,
      MNPA_CMD_POLL, MNPA_CMD_RESET} mnpa_cmd_t;
   typedef enum logic [1:0] {MNPA_RES_OK, MNPA_RES_FAIL, MNPA_RES_TIMEOUT} mnpa_res_t;
   typedef enum {MNPA_IDLE, MNPA_WLOW, MNPA_WHIGH, MNPA_RLOW, MNPA_RHOLD, MNPA_RSTLOW, MNPA_RSTWAIT,
      MNPA_DONE} mnpa_state_t;
endpackage

// ### hw/mnpa_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module mnpa_sync #(
   parameter int W = 1
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         meta_reg <= '0;
         q <= '0;
      end
      else
      begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule

// ### hw/mnpa_host.sv
// Host sequencer driving a multi-bank NOR flash over its parallel pins
// Notes on behaviour
// - Command writes carry bank bits on A19-A21
// - Protect: A6 low, A1 high, A0 low; reads 01h
// - Unprotect: A6 high, A1 high, A0 low; reads 00h
// - Acceleration pin may stay high across programs
`timescale 1ns/1ns
`include "mnpa_map.svh"
module mnpa_host #(
   parameter int READY_BUSY_CYC = `MNPA_READY_BUSY_CYC,
   parameter int AW = 22,
   parameter int DW = 16
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic cmd_valid,
   input wire mnpa_pkg::mnpa_cmd_t cmd_op,
   input wire logic [AW-1:0] cmd_addr,
   input wire logic [DW-1:0] cmd_data,
   input wire logic cmd_accel,
   input wire logic cmd_busy_hint,
   output logic cmd_ready,
   output logic rsp_valid,
   output mnpa_pkg::mnpa_res_t rsp_res,
   output logic [DW-1:0] rsp_data,
   output logic rsp_toggling,
   output logic [AW-1:0] fl_addr,
   input wire logic [DW-1:0] fl_dq_in,
   output logic [DW-1:0] fl_dq_out,
   output logic fl_dq_oe,
   output logic fl_ce_n,
   output logic fl_oe_n,
   output logic fl_we_n,
   output logic fl_reset_n,
   output logic fl_elevated_id_voltage
);
   import mnpa_pkg::*;

   // ************************************************
   // State
   // ************************************************
   localparam int CW = 16;
   typedef struct packed {
      mnpa_state_t st;
      mnpa_cmd_t op;
      logic [CW-1:0] cnt;
      logic [DW-1:0] last_rd;
      logic have_last;
      logic cmd_ready;
      logic rsp_valid;
      mnpa_res_t rsp_res;
      logic [DW-1:0] rsp_data;
      logic rsp_toggling;
      logic [AW-1:0] fl_addr;
      logic [DW-1:0] fl_dq_out;
      logic fl_dq_oe;
      logic fl_ce_n;
      logic fl_oe_n;
      logic fl_we_n;
      logic fl_reset_n;
      logic fl_vid;
   } mnpa_host_t;

   mnpa_host_t s_reg;
   mnpa_host_t s_next;
   logic [DW-1:0] dq_sync;

   mnpa_sync #(.W(DW)) u_dq_sync (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .d(fl_dq_in),
      .q(dq_sync)
   );

   // ************************************************
   // Sequencer
   // ************************************************
   always_comb
   begin
      s_next = s_reg;
      s_next.rsp_valid = 1'b0;
      case (s_reg.st)
         MNPA_IDLE:
         begin
            s_next.cmd_ready = 1'b1;
            if (cmd_valid && s_reg.cmd_ready)
            begin
               s_next.cmd_ready = 1'b0;
               s_next.op = cmd_op;
               s_next.fl_addr = cmd_addr;
               s_next.cnt = '0;
               s_next.fl_ce_n = 1'b0;
               // Accel level follows the request and stays up between programs
               s_next.fl_vid = cmd_accel;
               case (cmd_op)
                  MNPA_CMD_WRITE:
                  begin
                     s_next.fl_dq_out = cmd_data;
                     s_next.fl_dq_oe = 1'b0;
                     s_next.fl_we_n = 1'b0;
                     s_next.st = MNPA_WLOW;
                  end
                  MNPA_CMD_PROTECT, MNPA_CMD_UNPROTECT:
                  begin
                     // Group select stays on A12-A21 from the caller
                     s_next.fl_addr[`MNPA_A6] = (cmd_op == MNPA_CMD_UNPROTECT);
                     s_next.fl_addr[`MNPA_A1] = 1'b1;
                     s_next.fl_addr[`MNPA_A0] = 1'b0;
                     s_next.fl_oe_n = 1'b0;
                     s_next.st = MNPA_RLOW;
                  end
                  MNPA_CMD_READ, MNPA_CMD_POLL:
                  begin
                     s_next.fl_oe_n = 1'b0;
                     s_next.st = MNPA_RLOW;
                  end
                  MNPA_CMD_RESET:
                  begin
                     s_next.fl_ce_n = 1'b1;
                     s_next.fl_reset_n = 1'b0;
                     s_next.st = MNPA_RSTLOW;
                  end
                  default:
                  begin
                     s_next.fl_ce_n = 1'b1;
                     s_next.st = MNPA_DONE;
                  end
               endcase
            end
         end
         MNPA_WLOW:
         begin
            s_next.cnt = s_reg.cnt + 1'b1;
            if (s_reg.cnt + 1'b1 >= CW'(`MNPA_WE_LOW_CYC))
            begin
               s_next.fl_we_n = 1'b1;
               s_next.cnt = '0;
               s_next.st = MNPA_WHIGH;
            end
         end
         MNPA_WHIGH:
         begin
            s_next.cnt = s_reg.cnt + 1'b1;
            if (s_reg.cnt + 1'b1 >= CW'(`MNPA_WE_HIGH_CYC))
            begin
               s_next.fl_dq_oe = 1'b1;
               s_next.fl_ce_n = 1'b1;
               s_next.rsp_res = MNPA_RES_OK;
               s_next.st = MNPA_DONE;
            end
         end
         MNPA_RLOW:
         begin
            s_next.cnt = s_reg.cnt + 1'b1;
            // Extra two cycles cover the input synchroniser
            if (s_reg.cnt >= CW'(`MNPA_RD_CYC + 2))
            begin
               s_next.rsp_data = dq_sync;
               s_next.fl_oe_n = 1'b1;
               s_next.fl_ce_n = 1'b1;
               s_next.rsp_res = MNPA_RES_OK;
               if (s_reg.op == MNPA_CMD_PROTECT && dq_sync != `MNPA_ST_PROT)
                  s_next.rsp_res = MNPA_RES_FAIL;
               if (s_reg.op == MNPA_CMD_UNPROTECT && dq_sync != `MNPA_ST_UNPROT)
                  s_next.rsp_res = MNPA_RES_FAIL;
               if (s_reg.op == MNPA_CMD_POLL)
               begin
                  // Toggle compare against the previous poll
                  s_next.rsp_toggling = s_reg.have_last &&
                     (s_reg.last_rd[`MNPA_TOGGLE_BIT] != dq_sync[`MNPA_TOGGLE_BIT]);
                  s_next.last_rd = dq_sync;
                  s_next.have_last = 1'b1;
               end
               s_next.st = MNPA_DONE;
            end
         end
         MNPA_RSTLOW:
         begin
            s_next.cnt = s_reg.cnt + 1'b1;
            if (s_reg.cnt + 1'b1 >= CW'(`MNPA_RST_PULSE_CYC))
            begin
               s_next.fl_reset_n = 1'b1;
               s_next.cnt = '0;
               s_next.st = MNPA_RSTWAIT;
            end
         end
         MNPA_RSTWAIT:
         begin
            // Wait covers the device's worst recovery for the hinted state
            s_next.cnt = s_reg.cnt + 1'b1;
            if (s_reg.cnt + 1'b1 >= (cmd_busy_hint ? CW'(READY_BUSY_CYC) : CW'(`MNPA_READY_IDLE_CYC)))
            begin
               s_next.have_last = 1'b0;
               s_next.rsp_toggling = 1'b0;
               s_next.rsp_res = MNPA_RES_OK;
               s_next.st = MNPA_DONE;
            end
         end
         MNPA_DONE:
         begin
            s_next.rsp_valid = 1'b1;
            s_next.cnt = '0;
            s_next.st = MNPA_IDLE;
         end
         default:
         begin
            s_next.st = MNPA_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         s_reg <= '{st: MNPA_IDLE, op: MNPA_CMD_READ, cnt: '0, last_rd: '0, have_last: 1'b0,
            cmd_ready: 1'b0, rsp_valid: 1'b0, rsp_res: MNPA_RES_OK, rsp_data: '0, rsp_toggling: 1'b0,
            fl_addr: '0, fl_dq_out: '0, fl_dq_oe: 1'b1, fl_ce_n: 1'b1, fl_oe_n: 1'b1, fl_we_n: 1'b1,
            fl_reset_n: 1'b1, fl_vid: 1'b0};
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign cmd_ready = s_reg.cmd_ready;
   assign rsp_valid = s_reg.rsp_valid;
   assign rsp_res = s_reg.rsp_res;
   assign rsp_data = s_reg.rsp_data;
   assign rsp_toggling = s_reg.rsp_toggling;
   assign fl_addr = s_reg.fl_addr;
   assign fl_dq_out = s_reg.fl_dq_out;
   assign fl_dq_oe = s_reg.fl_dq_oe;
   assign fl_ce_n = s_reg.fl_ce_n;
   assign fl_oe_n = s_reg.fl_oe_n;
   assign fl_we_n = s_reg.fl_we_n;
   assign fl_reset_n = s_reg.fl_reset_n;
   assign fl_elevated_id_voltage = s_reg.fl_vid;

   // ************************************************
   // Checks
   // ************************************************
   a_bank_bits_held: assert property (@(posedge clk_sys) disable iff (!rstn)
      (!fl_we_n) |=> $stable(fl_addr[`MNPA_BANK_MSB:`MNPA_BANK_LSB]))
      else $error("Bank bits changed during write pulse");
   a_protect_pins: assert property (@(posedge clk_sys) disable iff (!rstn)
      (!fl_oe_n && s_reg.op == MNPA_CMD_PROTECT) |-> (!fl_addr[6] && fl_addr[1] && !fl_addr[0]))
      else $error("Protect address pattern wrong");
   a_unprotect_pins: assert property (@(posedge clk_sys) disable iff (!rstn)
      (!fl_oe_n && s_reg.op == MNPA_CMD_UNPROTECT) |-> (fl_addr[6] && fl_addr[1] && !fl_addr[0]))
      else $error("Unprotect address pattern wrong");
   a_we_pulse_len: assert property (@(posedge clk_sys) disable iff (!rstn)
      $fell(fl_we_n) |-> !fl_we_n ##1 fl_we_n)
      else $error("Write pulse length wrong");
   a_reset_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
      $fell(fl_reset_n) |-> (!fl_reset_n)[*8] ##1 (!fl_reset_n) [*2] ##1 fl_reset_n)
      else $error("Reset pulse length wrong");
   a_vid_steady: assert property (@(posedge clk_sys) disable iff (!rstn)
      (s_reg.st != MNPA_IDLE) |=> $stable(fl_elevated_id_voltage))
      else $error("Accel level changed mid operation");
   a_status_check: assert property (@(posedge clk_sys) disable iff (!rstn)
      (rsp_valid && s_reg.op == MNPA_CMD_PROTECT && rsp_data == `MNPA_ST_PROT) |-> rsp_res == MNPA_RES_OK)
      else $error("Protected status not accepted");
   a_toggle_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
      (rsp_valid && s_reg.op == MNPA_CMD_RESET) |-> !rsp_toggling)
      else $error("Toggle state survived reset");
endmodule

// ### verif/mnpa_flash_model.sv
// Behavioural NOR flash answering the host sequencer pins
`timescale 1ns/1ns
module mnpa_flash_model (
   input wire logic [21:0] fl_addr,
   input wire logic [15:0] fl_dq_out,
   input wire logic fl_dq_oe,
   input wire logic fl_ce_n,
   input wire logic fl_oe_n,
   input wire logic fl_we_n,
   input wire logic fl_reset_n,
   input wire logic fl_elevated_id_voltage,
   output logic [15:0] fl_dq_in
);
   logic [15:0] mem [int];
   logic prot [int];
   logic [2:0] last_bank = 3'h0;
   logic tog = 1'b0;
   logic [15:0] last = 16'h0;
   int busy = 0;
   int accel_cnt = 0;
   // Released bus shows the inverse of the last word, never a stale copy
   assign fl_dq_in = (!fl_ce_n && !fl_oe_n && fl_dq_oe) ? last : ~last;
   always @(negedge fl_oe_n)
   begin
      #1;
      if (busy > 0)
      begin
         tog = ~tog;
         busy--;
         last = {9'h0, tog, 6'h0};
      end
      else if (fl_addr[1] && !fl_addr[0])
      begin
         prot[fl_addr[21:12]] = !fl_addr[6];
         last = prot[fl_addr[21:12]] ? 16'h0001 : 16'h0000;
      end
      else if (mem.exists(fl_addr))
         last = mem[fl_addr];
      else
         last = (fl_addr >= 22'h3f8000) ? {6'h0, fl_addr[21:12]} : {6'h0, fl_addr[21:15], 3'h0};
   end
   always @(posedge fl_we_n)
      if (!fl_ce_n && fl_reset_n && !fl_dq_oe)
      begin
         mem[fl_addr] = fl_dq_out;
         last_bank = fl_addr[21:19];
         if (fl_elevated_id_voltage)
            accel_cnt++;
         busy = 3;
      end
   always @(negedge fl_reset_n)
      busy = 0;
endmodule

// ### verif/multibank_nor_protect_accel_map_tb_top.sv
// Self-checking bench for the NOR host sequencer
`timescale 1ns/1ns
`include "mnpa_map.svh"
module multibank_nor_protect_accel_map_tb_top;
   import mnpa_pkg::*;
   localparam int RB = 20;
   logic clk_sys = 0, rstn = 0, cmd_valid = 0, cmd_accel = 0, cmd_busy_hint = 0;
   mnpa_cmd_t cmd_op = MNPA_CMD_READ;
   logic [21:0] cmd_addr = 22'h0, fl_addr, a;
   logic [15:0] cmd_data = 16'h0, rsp_data, fl_dq_in, fl_dq_out, d;
   logic cmd_ready, rsp_valid, rsp_toggling, fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, fl_reset_n, fl_vid;
   mnpa_res_t rsp_res;
   int n_mismatch = 0, check_count = 0, lat = 0, seed = 32'h9f38;
   logic [15:0] exp_mem [int];
   mnpa_host #(.READY_BUSY_CYC(RB)) DUT (.clk_sys(clk_sys), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_accel(cmd_accel), .cmd_busy_hint(cmd_busy_hint),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_res(rsp_res), .rsp_data(rsp_data),
      .rsp_toggling(rsp_toggling), .fl_addr(fl_addr), .fl_dq_in(fl_dq_in), .fl_dq_out(fl_dq_out),
      .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_reset_n(fl_reset_n),
      .fl_elevated_id_voltage(fl_vid));
   mnpa_flash_model FM (.fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n),
      .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_reset_n(fl_reset_n), .fl_elevated_id_voltage(fl_vid),
      .fl_dq_in(fl_dq_in));
   initial
      forever #25 clk_sys = ~clk_sys;
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic run(input mnpa_cmd_t op, input logic [21:0] ad, input logic [15:0] dt, input logic acc,
      input logic hint);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 50)
      begin
         @(posedge clk_sys);
         #5;
         n++;
      end
      if (cmd_ready !== 1'b1)
      begin
         n_mismatch++;
         $display("wrong value at %0t: request never accepted", $time);
      end
      cmd_op = op;
      cmd_addr = ad;
      cmd_data = dt;
      cmd_accel = acc;
      cmd_busy_hint = hint;
      cmd_valid = 1'b1;
      @(posedge clk_sys);
      #5;
      cmd_valid = 1'b0;
      lat = 0;
      // Latency counted in edges after the taking edge
      do
      begin
         @(posedge clk_sys);
         #1;
         lat++;
      end while (rsp_valid !== 1'b1 && lat < 200);
      if (rsp_valid !== 1'b1)
      begin
         n_mismatch++;
         $display("wrong value at %0t: no response", $time);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ****************************************
   // Tests
   // ****************************************
   initial
   begin
      repeat (4) @(posedge clk_sys);
      #5;
      rstn = 1'b1;
      run(MNPA_CMD_RESET, 22'h0, 16'h0, 1'b0, 1'b0);
      chk(lat, `MNPA_RST_PULSE_CYC + `MNPA_READY_IDLE_CYC + 1, "idle reset latency");
      for (int i = 0; i < 3; i++)
      begin
         a = (i == 0) ? `MNPA_TOP_PARAM : (i == 1) ? `MNPA_FIRST_MAIN : 22'h300000;
         a = a | (22'($random(seed)) & 22'h000ffc);
         run(MNPA_CMD_READ, a, 16'h0, 1'b0, 1'b0);
         chk(rsp_data, (a >= 22'h3f8000) ? {6'h0, a[21:12]} : {6'h0, a[21:15], 3'h0}, "block map");
      end
      // Access time, two synchroniser stages, one sample cycle and the response cycle
      chk(lat, `MNPA_RD_CYC + 4, "read latency");
      $display("test map done");
      a = 22'($random(seed)) & 22'h3ff000;
      run(MNPA_CMD_PROTECT, a, 16'h0, 1'b0, 1'b0);
      chk({rsp_res, rsp_data}, {MNPA_RES_OK, `MNPA_ST_PROT}, "protect status");
      run(MNPA_CMD_UNPROTECT, a, 16'h0, 1'b0, 1'b0);
      chk({rsp_res, rsp_data}, {MNPA_RES_OK, `MNPA_ST_UNPROT}, "unprotect status");
      $display("test protect done");
      a = 22'($random(seed)) & 22'h3ffffc;
      d = 16'($random(seed));
      exp_mem[a] = d;
      run(MNPA_CMD_WRITE, a, d, 1'b0, 1'b0);
      chk(lat, `MNPA_WE_LOW_CYC + `MNPA_WE_HIGH_CYC + 1, "write latency");
      chk(FM.last_bank, a[21:19], "bank bits");
      repeat (2) run(MNPA_CMD_POLL, a, 16'h0, 1'b0, 1'b0);
      chk(rsp_toggling, 1'b1, "toggle while busy");
      repeat (3) run(MNPA_CMD_POLL, a, 16'h0, 1'b0, 1'b0);
      chk(rsp_toggling, 1'b0, "toggle after done");
      run(MNPA_CMD_READ, a, 16'h0, 1'b0, 1'b0);
      chk(rsp_data, exp_mem[a], "readback");
      $display("test write done");
      for (int i = 0; i < 2; i++)
      begin
         exp_mem[a] = d + 16'(i);
         run(MNPA_CMD_WRITE, a, exp_mem[a], 1'b1, 1'b0);
         chk(fl_vid, 1'b1, "accel pin held");
      end
      chk(FM.accel_cnt, 2, "accel writes taken");
      run(MNPA_CMD_RESET, 22'h0, 16'h0, 1'b0, 1'b1);
      chk(lat, `MNPA_RST_PULSE_CYC + RB + 1, "busy reset latency");
      chk(FM.busy, 0, "routine aborted");
      run(MNPA_CMD_READ, a, 16'h0, 1'b0, 1'b0);
      chk(rsp_data, exp_mem[a], "readback after abort");
      $display("test accel done");
      finish_test;
   end
   initial
   begin
      #(3000 * 50);
      n_mismatch++;
      $display("wrong value at %0t: watchdog expired", $time);
      finish_test;
   end
endmodule
